//--- rtl/flash_write_path.sv
// Write, program and erase sequencer of a page-erasable serial flash.
// Assumes an SPI master on spi_clk; pins are synchronised into clk_sys.
//
// Operation
// [R1] Top lock input low makes the highest 256 pages read-only.
// [R2] Top lock input high gives those pages ordinary protection only.
// [R3] Hardware protect input freezes the two protect-size bits.
// [R4] Only clock modes 0 and 3; sample on rise, drive after fall.
// [R5] Master parks clock low in mode 0, high in mode 3.
// [R6] Master selects one device at a time on the shared bus.
// [R7] Master sends unlock, then opcode, three address bytes and data.
// [R8] Up to 256 data bytes per sequence, wrapping inside one page.
// [R9] Program only clears bits; merge write sets bits to 0 or 1.
// [R10] Merge write framing: select low, opcode, A23-A0, data, select high.
// [R11] Data bytes fill the buffer from the low address byte onward.
// [R12] Internal merge-write cycle starts when select rises.
// [R13] Bytes not supplied are filled from the addressed page.
// [R14] Then the page is erased and programmed from the buffer.
// [R15] Master should send a page's bytes in one sequence.
// [R16] Master uses program only on erased bytes or to clear bits.
// [R17] Busy flag visible in status while an internal cycle runs.
// [R18] Host holds reset pin low until supply is valid.
// [R19] Modifying opcodes run only with the unlock latch set.
// [R20] Unlock latch clears on completion and while reset pin is low.
// [R21] Data output is high impedance while deselected.
// [R22] Busy sets on select rise, clears when final step ends.
module flash_write_path #(
  parameter int MEM_BYTES = flash_pkg::MEM_BYTES_DEF,
  parameter int ERASE_WAIT = flash_pkg::ERASE_CYCLES,
  parameter int PROG_WAIT = flash_pkg::PROG_CYCLES
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic spi_clk, // SPI serial clock
  input wire logic cs_n, // SPI select, active low
  input wire logic mosi, // SPI data in
  output logic miso, // SPI data out
  output logic miso_oe, // SPI data out enable
  input wire logic reset_pin_n, // Device reset pin, active low
  input wire logic top_block_lock_n, // Top block lock pin, active low
  input wire logic write_protect_n, // Protect-size freeze pin, active low
  output logic busy_flag, // Internal cycle running
  output logic write_unlock_latch, // Modifying opcodes enabled
  output logic protect_size_hi, // Protected area size, high bit
  output logic protect_size_lo, // Protected area size, low bit
  output logic hw_protected_state // Protect-size bits frozen
);
  import flash_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);

  if (MEM_BYTES < BLOCK_BYTES || (1 << AW) != MEM_BYTES || AW > 24 ||
      ERASE_WAIT < 1 || PROG_WAIT < 1) begin : g_bad_size
    $error("flash_write_path: unsupported size or wait parameter");
  end

  logic [3:0] cs_sync_q;
  logic [1:0] rst_sync_q;
  logic [1:0] lock_sync_q;
  logic [1:0] wp_sync_q;
  logic [2:0] tgl_sync_q;
  logic [7:0] link_byte;
  logic link_tgl;
  logic [7:0] status_q;
  seq_e fsm_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [2:0] nbytes_q;
  logic [7:0] idx_q;
  logic got_data_q;
  logic got_status_q;
  logic [1:0] wr_ps_q;
  logic pw_q;
  logic busy_q;
  logic wul_q;
  logic [1:0] ps_q;
  logic hwp_q;
  logic [AW-1:0] er_addr_q;
  logic [AW-1:0] er_last_q;
  logic [31:0] wait_q;
  logic [7:0] buf_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_q;
  logic [7:0] mem_q [MEM_BYTES];

  logic frame_start, frame_end, byte_ev, rst_s, lock_s;
  logic is_prog, is_erase, blocked, accept_mod, accept_ps, done_ev, wait_done;
  logic [AW-1:0] tgt_first, tgt_last, prog_a;
  logic [7:0] mem_rd, prog_data;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cs_sync_q <= 4'hF;
      rst_sync_q <= 2'h0;
      lock_sync_q <= 2'h3;
      wp_sync_q <= 2'h3;
      tgl_sync_q <= 3'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[2:0], cs_n};
      rst_sync_q <= {rst_sync_q[0], reset_pin_n};
      lock_sync_q <= {lock_sync_q[0], top_block_lock_n};
      wp_sync_q <= {wp_sync_q[0], write_protect_n};
      tgl_sync_q <= {tgl_sync_q[1:0], link_tgl};
    end
  end

  // End of frame is seen one cycle after the last byte event can arrive
  assign frame_start = cs_sync_q[2] && !cs_sync_q[1];
  assign frame_end = !cs_sync_q[3] && cs_sync_q[2];
  assign byte_ev = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign rst_s = rst_sync_q[1];
  assign lock_s = lock_sync_q[1];

  spi_link u_link (
    .spi_clk(spi_clk),
    .cs_n(cs_n),
    .mosi(mosi),
    .sys_rst(sys_rst),
    .status_in(status_q),
    .byte_data(link_byte),
    .byte_tgl(link_tgl),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  always_comb begin
    int span;
    span = op_span(op_q, MEM_BYTES);
    is_prog = (op_q == CMD_MERGE_WRITE) || (op_q == CMD_PAGE_PROGRAM);
    is_erase = (op_q == CMD_PAGE_ERASE) || (op_q == CMD_SUBBLOCK_ERASE) ||
               (op_q == CMD_BLOCK_ERASE) || (op_q == CMD_FULL_ERASE);
    tgt_first = addr_q[AW-1:0] & ~AW'(span - 1);
    tgt_last = tgt_first | AW'(span - 1);
    // Regions grow downward from the top, so checking the last byte suffices
    blocked = int'(tgt_last) >= prot_base(ps_q, lock_s, MEM_BYTES); // see [R1] see [R2]
    accept_mod = fsm_q == S_FRAME && frame_end && wul_q && !blocked && // see [R19]
                 ((is_prog && got_data_q) ||
                  (is_erase && op_q != CMD_FULL_ERASE && nbytes_q == HDR_BYTES) ||
                  (op_q == CMD_FULL_ERASE && nbytes_q == 3'h1));
    accept_ps = fsm_q == S_FRAME && frame_end && wul_q && got_status_q &&
                op_q == CMD_WRITE_STATUS && nbytes_q == 3'h2;
    wait_done = wait_q == 32'(ERASE_WAIT - 1) && fsm_q == S_WAIT_E ||
                wait_q == 32'(PROG_WAIT - 1) && fsm_q == S_WAIT_P;
    done_ev = wait_done && (fsm_q == S_WAIT_P || !pw_q);
    prog_a = {addr_q[AW-1:8], idx_q};
    mem_rd = mem_q[prog_a];
    // Plain program can only pull bits low; merge write takes the buffer as is
    prog_data = pw_q ? buf_q[idx_q] :
                (valid_q[idx_q] ? (mem_rd & buf_q[idx_q]) : mem_rd); // see [R9]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fsm_q <= S_IDLE;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      nbytes_q <= 3'h0;
      idx_q <= 8'h00;
      got_data_q <= 1'b0;
      got_status_q <= 1'b0;
      wr_ps_q <= PS_RESET;
      pw_q <= 1'b0;
      er_addr_q <= '0;
      er_last_q <= '0;
      wait_q <= 32'h0;
    end else if (!rst_s) begin
      fsm_q <= S_IDLE;
    end else begin
      unique case (fsm_q)
        S_IDLE: begin
          nbytes_q <= 3'h0;
          got_data_q <= 1'b0;
          got_status_q <= 1'b0;
          if (frame_start) fsm_q <= S_FRAME;
        end
        S_FRAME: begin
          if (byte_ev) begin
            if (nbytes_q != 3'h7) nbytes_q <= nbytes_q + 3'h1;
            if (nbytes_q == 3'h0) op_q <= link_byte;
            if (nbytes_q != 3'h0 && nbytes_q < HDR_BYTES) addr_q <= {addr_q[15:0], link_byte};
            if (nbytes_q == 3'h1 && op_q == CMD_WRITE_STATUS) begin
              wr_ps_q <= {link_byte[ST_PS_HI], link_byte[ST_PS_LO]};
              got_status_q <= 1'b1;
            end
            if (nbytes_q == 3'h3) idx_q <= link_byte; // see [R11]
            if (nbytes_q >= HDR_BYTES && is_prog) begin
              idx_q <= idx_q + 8'h01; // see [R8]
              got_data_q <= 1'b1;
            end
          end
          if (frame_end) begin
            fsm_q <= S_IDLE;
            if (accept_mod) begin
              pw_q <= op_q == CMD_MERGE_WRITE;
              er_addr_q <= tgt_first;
              er_last_q <= tgt_last;
              idx_q <= 8'h00;
              if (op_q == CMD_MERGE_WRITE) fsm_q <= S_FILL; // see [R12]
              else if (op_q == CMD_PAGE_PROGRAM) fsm_q <= S_PROG;
              else fsm_q <= S_ERASE;
            end
          end
        end
        S_FILL: begin
          idx_q <= idx_q + 8'h01;
          if (idx_q == 8'hFF) fsm_q <= S_ERASE; // see [R14]
        end
        S_ERASE: begin
          er_addr_q <= er_addr_q + AW'(1);
          wait_q <= 32'h0;
          if (er_addr_q == er_last_q) fsm_q <= S_WAIT_E;
        end
        S_WAIT_E: begin
          wait_q <= wait_q + 32'h1;
          if (wait_done) fsm_q <= pw_q ? S_PROG : S_IDLE; // see [R14]
        end
        S_PROG: begin
          idx_q <= idx_q + 8'h01;
          wait_q <= 32'h0;
          if (idx_q == 8'hFF) fsm_q <= S_WAIT_P;
        end
        S_WAIT_P: begin
          wait_q <= wait_q + 32'h1;
          if (wait_done) fsm_q <= S_IDLE;
        end
        default: fsm_q <= S_IDLE;
      endcase
    end
  end

  // Page buffer: supplied bytes first, then the gaps from the array
  always_ff @(posedge clk_sys) begin
    if (fsm_q == S_FRAME && byte_ev && nbytes_q >= HDR_BYTES && is_prog) begin
      buf_q[idx_q] <= link_byte; // see [R11]
    end else if (fsm_q == S_FILL && !valid_q[idx_q]) begin
      buf_q[idx_q] <= mem_rd; // see [R13]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= '0;
    end else if (fsm_q == S_FRAME && byte_ev && nbytes_q == 3'h3) begin
      valid_q <= '0;
    end else if (fsm_q == S_FRAME && byte_ev && nbytes_q >= HDR_BYTES && is_prog) begin
      valid_q[idx_q] <= 1'b1;
    end
  end

  // Array has no reset; contents are unknown until erased
  always_ff @(posedge clk_sys) begin
    if (fsm_q == S_ERASE) mem_q[er_addr_q] <= ERASED_BYTE; // see [R14]
    else if (fsm_q == S_PROG) mem_q[prog_a] <= prog_data; // see [R14]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (!rst_s) begin
      busy_q <= 1'b0;
    end else if (accept_mod) begin
      busy_q <= 1'b1; // see [R17] see [R22]
    end else if (done_ev) begin
      busy_q <= 1'b0; // see [R22]
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wul_q <= 1'b0;
    end else if (!rst_s) begin
      wul_q <= 1'b0; // see [R20]
    end else if (fsm_q == S_FRAME && frame_end && op_q == CMD_WRITE_UNLOCK && nbytes_q == 3'h1) begin
      wul_q <= 1'b1;
    end else if (done_ev || accept_ps) begin
      wul_q <= 1'b0; // see [R20]
    end
  end

  // Size bits stay put while the protect pin is asserted
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ps_q <= PS_RESET;
      hwp_q <= 1'b0;
      status_q <= 8'h00;
    end else begin
      hwp_q <= !wp_sync_q[1];
      if (accept_ps && !hwp_q) ps_q <= wr_ps_q; // see [R3]
      status_q <= 8'h00;
      status_q[ST_BUSY] <= busy_q; // see [R17]
      status_q[ST_UNLOCK] <= wul_q;
      status_q[ST_PS_LO] <= ps_q[0];
      status_q[ST_PS_HI] <= ps_q[1];
    end
  end

  assign busy_flag = busy_q;
  assign write_unlock_latch = wul_q;
  assign protect_size_hi = ps_q[1];
  assign protect_size_lo = ps_q[0];
  assign hw_protected_state = hwp_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_top_lock;
    (fsm_q == S_ERASE || fsm_q == S_PROG) && !lock_s && $stable(lock_s) |->
      int'(fsm_q == S_ERASE ? er_addr_q : prog_a) < MEM_BYTES - TOP_LOCK_BYTES;
  endproperty
  a_top_lock: assert property (p_top_lock) else $error("top block written while locked"); // see [R1]
  property p_freeze;
    hwp_q && $past(hwp_q) |=> $stable(ps_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("size bits changed while frozen"); // see [R3]
  property p_page_wrap;
    fsm_q == S_FRAME && byte_ev && nbytes_q >= HDR_BYTES && is_prog |=>
      idx_q == $past(idx_q) + 8'h01 && addr_q == $past(addr_q);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("data left its page"); // see [R8]
  property p_clear_only;
    fsm_q == S_PROG && !pw_q |-> (prog_data & ~mem_rd) == 8'h00;
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("program set a bit"); // see [R9]
  property p_start_offset;
    fsm_q == S_FRAME && byte_ev && nbytes_q == 3'h3 |=> idx_q == $past(link_byte) && valid_q == '0;
  endproperty
  a_start_offset: assert property (p_start_offset) else $error("wrong buffer start"); // see [R11]
  property p_busy_start;
    $rose(busy_q) |-> $past(frame_end) && $past(wul_q);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("cycle began without select rise"); // see [R12]
  property p_fill;
    fsm_q == S_FILL && !valid_q[idx_q] |=> buf_q[$past(idx_q)] == $past(mem_rd);
  endproperty
  a_fill: assert property (p_fill) else $error("gap not filled from page"); // see [R13]
  property p_fill_erase;
    fsm_q == S_FILL && idx_q == 8'hFF |=> fsm_q == S_ERASE ##[1:300] fsm_q == S_WAIT_E;
  endproperty
  a_fill_erase: assert property (p_fill_erase) else $error("fill not followed by erase"); // see [R14]
  property p_busy_state;
    busy_q == (fsm_q inside {S_FILL, S_ERASE, S_WAIT_E, S_PROG, S_WAIT_P});
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("busy flag out of step"); // see [R17]
  property p_unlock_done;
    $fell(busy_q) && rst_s |-> !wul_q && $past(done_ev);
  endproperty
  a_unlock_done: assert property (p_unlock_done) else $error("latch kept after cycle"); // see [R20]
  property p_hiz;
    cs_sync_q[1] |-> !miso_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while deselected"); // see [R21]

  c_merge: cover property (fsm_q == S_WAIT_P && pw_q && wait_done);
  c_program: cover property (fsm_q == S_WAIT_P && !pw_q && wait_done);
  c_erase: cover property (fsm_q == S_WAIT_E && !pw_q && wait_done);
  c_status_read: cover property ($rose(miso_oe));
endmodule : flash_write_path

//--- shared/flash_pkg.sv
// Shared constants for the paged serial flash write path.
// Assumes a 100 MHz system clock and an SPI master in clock mode 0 or 3.
package flash_pkg;
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_MERGE_WRITE = 8'h0A;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'hDB;
  localparam logic [7:0] CMD_SUBBLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] CMD_FULL_ERASE = 8'hC7;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;

  localparam int PAGE_BYTES = 256;
  localparam int SUBBLOCK_BYTES = 4096;
  localparam int BLOCK_BYTES = 65536;
  localparam int TOP_LOCK_PAGES = 256;
  localparam int TOP_LOCK_BYTES = TOP_LOCK_PAGES * PAGE_BYTES;
  localparam int MEM_BYTES_DEF = 262144;
  localparam logic [2:0] HDR_BYTES = 3'h4;

  localparam int CLK_PERIOD_NS = 10;
  localparam int T_PAGE_ERASE_US = 10000;
  localparam int T_PAGE_PROG_US = 800;
  localparam int ERASE_CYCLES = (T_PAGE_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (T_PAGE_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ST_BUSY = 0;
  localparam int ST_UNLOCK = 1;
  localparam int ST_PS_LO = 2;
  localparam int ST_PS_HI = 3;
  localparam logic [1:0] PS_RESET = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FRAME = 3'h1,
    S_FILL = 3'h2,
    S_ERASE = 3'h3,
    S_WAIT_E = 3'h4,
    S_PROG = 3'h5,
    S_WAIT_P = 3'h6
  } seq_e;

  // Lowest protected byte address; mem_bytes when nothing is protected
  function automatic int prot_base(logic [1:0] ps, logic lock_n, int mem_bytes);
    int base;
    unique case (ps)
      2'h1: base = mem_bytes - mem_bytes / 4;
      2'h2: base = mem_bytes / 2;
      2'h3: base = 0;
      default: base = mem_bytes;
    endcase
    if (!lock_n && base > mem_bytes - TOP_LOCK_BYTES) base = mem_bytes - TOP_LOCK_BYTES;
    return base;
  endfunction : prot_base

  // Bytes touched by a modifying opcode; zero for anything else
  function automatic int op_span(logic [7:0] op, int mem_bytes);
    unique case (op)
      CMD_MERGE_WRITE, CMD_PAGE_PROGRAM, CMD_PAGE_ERASE: return PAGE_BYTES;
      CMD_SUBBLOCK_ERASE: return SUBBLOCK_BYTES;
      CMD_BLOCK_ERASE: return BLOCK_BYTES;
      CMD_FULL_ERASE: return mem_bytes;
      default: return 0;
    endcase
  endfunction : op_span
endpackage : flash_pkg

//--- rtl/spi_link.sv
// SPI shift logic running on the master's serial clock.
// Assumes clock mode 0 or 3; the clock may stop outside frames.
module spi_link (
  input wire logic spi_clk, // Serial clock from master
  input wire logic cs_n, // Select, active low
  input wire logic mosi, // Serial data in
  input wire logic sys_rst, // System reset, active high
  input wire logic [7:0] status_in, // Status byte, system domain
  output logic [7:0] byte_data, // Last complete byte
  output logic byte_tgl, // Toggles per complete byte
  output logic miso, // Serial data out
  output logic miso_oe // High while driving miso
);
  import flash_pkg::*;

  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic opcode_done_q;
  logic rdsr_q;
  logic [7:0] byte_q;
  logic tgl_q;
  logic [7:0] st_meta_q;
  logic [7:0] st_sync_q;
  logic [7:0] out_q;
  logic oe_q;
  logic [7:0] rx_byte;

  assign rx_byte = {shift_q, mosi};

  // Input sampled on the rising edge in both modes (see [R4])
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      opcode_done_q <= 1'b0;
      rdsr_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= rx_byte[6:0];
      if (bit_cnt_q == 3'h7 && !opcode_done_q) begin
        opcode_done_q <= 1'b1;
        rdsr_q <= (rx_byte == CMD_READ_STATUS);
      end
    end
  end

  // Byte held stable for eight clocks, long enough for the toggle to cross
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_q <= 8'h00;
      tgl_q <= 1'b0;
      st_meta_q <= 8'h00;
      st_sync_q <= 8'h00;
    end else begin
      st_meta_q <= status_in;
      st_sync_q <= st_meta_q;
      if (bit_cnt_q == 3'h7 && !cs_n) begin
        byte_q <= rx_byte;
        tgl_q <= ~tgl_q;
      end
    end
  end

  // Output changes after the falling edge; released the moment select rises
  always_ff @(negedge spi_clk or posedge cs_n or posedge sys_rst) begin
    if (cs_n || sys_rst) begin
      out_q <= 8'h00;
      oe_q <= 1'b0; // see [R21]
    end else if (bit_cnt_q == 3'h0 && rdsr_q) begin
      out_q <= st_sync_q; // see [R4]
      oe_q <= 1'b1;
    end else begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign byte_data = byte_q;
  assign byte_tgl = tgl_q;
  assign miso = out_q[7];
  assign miso_oe = oe_q;
endmodule : spi_link

//--- dv/spi_master_model.sv
// SPI bus master model that drives the flash write path.
// Assumes it is the only master and this the only device; mode 0 or 3 per frame.
module spi_master_model (
  output logic spi_clk, // Serial clock
  output logic cs_n, // Select, active low
  output logic mosi, // Data to device
  input wire logic miso, // Data from device
  input wire logic miso_oe // Device drives miso
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF_NS = 32;
  logic [7:0] rx_byte = 8'h00;
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1; // Only one device is ever selected
    mosi = 1'b0;
  end
  task automatic frame(input logic [7:0] bytes[$], input logic mode3);
    spi_clk = mode3; // Idle level follows the mode
    // Frames start on a system falling edge; an even offset keeps select off its rising edge
    #(4 * HALF_NS + 2);
    cs_n = 1'b0;
    #(HALF_NS);
    foreach (bytes[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spi_clk = 1'b0;
        mosi = bytes[i][k]; // Opcode, address, data, MSB first
        #(HALF_NS);
        spi_clk = 1'b1; // Both modes sample on the rise
        rx_byte = {rx_byte[6:0], miso_oe ? miso : ~rx_byte[0]};
        #(HALF_NS);
      end
    end
    spi_clk = mode3;
    #(6 * HALF_NS);
    cs_n = 1'b1;
    mosi = ~mosi; // A released line must not look like held data
  endtask : frame
endmodule : spi_master_model

//--- dv/test_spi_paged_flash_write_path.sv
// Self-checking bench for the paged flash write path.
// Assumes a 100 MHz system clock and the SPI master model on the link.
module test_spi_paged_flash_write_path;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_pkg::*;
  typedef struct {
    string name;
    logic from_rx;
    logic [7:0] val;
  } note_s;
  note_s notes[$];
  note_s cur;
  logic [7:0] seen;
  logic [7:0] tx[$];
  // Erases come first on one page so that merge and program never read an unknown array
  logic [7:0] ops[4] = '{CMD_PAGE_ERASE, CMD_SUBBLOCK_ERASE, CMD_MERGE_WRITE, CMD_PAGE_PROGRAM};
  logic [7:0] page;
  logic [1:0] exp_size = 2'h0;
  logic exp_latch = 1'b0;
  logic exp_hw = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 32'hDC2E82C8;
  logic clk_sys = 1'b0;
  logic sys_rst, reset_pin_n, top_block_lock_n, write_protect_n;
  logic spi_clk, cs_n, mosi, miso, miso_oe;
  logic busy_flag, write_unlock_latch, protect_size_hi, protect_size_lo, hw_protected_state;

  always #5 clk_sys = ~clk_sys;

  // Short waits keep the run brief; 64 KB puts the whole array in the top 256 pages
  flash_write_path #(.MEM_BYTES(65536), .ERASE_WAIT(16), .PROG_WAIT(8)) flash_write_path_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .reset_pin_n(reset_pin_n),
    .top_block_lock_n(top_block_lock_n), .write_protect_n(write_protect_n),
    .busy_flag(busy_flag), .write_unlock_latch(write_unlock_latch),
    .protect_size_hi(protect_size_hi), .protect_size_lo(protect_size_lo),
    .hw_protected_state(hw_protected_state)
  );
  spi_master_model spi_master_model_inst (
    .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
  );

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Queue a note; the monitor compares it at the next falling edge
  task automatic note(input string name, input logic from_rx, input logic [7:0] val);
    #1;
    notes.push_back('{name, from_rx, val});
    @(negedge clk_sys);
  endtask : note

  task automatic note_pins(input string name, input logic busy);
    note(name, 1'b0, {2'h0, exp_hw, 1'b0, exp_size, exp_latch, busy});
  endtask : note_pins

  // Kind: 0 refused, 1 unlock, 2 internal cycle, 3 status write
  task automatic op(input logic mode3, input int kind);
    spi_master_model_inst.frame(tx, mode3);
    repeat (3) @(posedge clk_sys);
    note_pins("busy_early", 1'b0);
    repeat (4) @(posedge clk_sys);
    if (kind == 1) exp_latch = 1'b1;
    if (kind != 3) note_pins("busy_late", kind == 2);
    if (kind == 2) begin
      tx = {CMD_READ_STATUS, 8'h00, 8'h00};
      spi_master_model_inst.frame(tx, mode3);
      note("status_read", 1'b1, {4'h0, exp_size, 2'h3});
    end
    for (int i = 0; i < 6000 && busy_flag !== 1'b0; i++) @(posedge clk_sys);
    if (kind >= 2) exp_latch = 1'b0;
    if (kind == 3 && !exp_hw) exp_size = tx[1][3:2];
    note_pins("busy_done", 1'b0);
  endtask : op

  task automatic unlock(input logic mode3);
    tx = {CMD_WRITE_UNLOCK};
    op(mode3, 1);
  endtask : unlock

  always @(negedge clk_sys) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      seen = cur.from_rx ? spi_master_model_inst.rx_byte : {2'h0, hw_protected_state, miso_oe,
        protect_size_hi, protect_size_lo, write_unlock_latch, busy_flag};
      checks_done++;
      if (seen !== cur.val) begin
        bad_count++;
        $display("Error %s expected %h seen %h", cur.name, cur.val, seen);
      end
    end
  end

  // Whole run needs about 10000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      $display("Error timeout expected idle seen running");
      final_report();
    end
  end

  initial begin
    sys_rst = 1'b1;
    reset_pin_n = 1'b1; // Held high as supply is already valid
    top_block_lock_n = 1'b0;
    write_protect_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    note_pins("after_reset", 1'b0);
    tx = {CMD_MERGE_WRITE, 8'h00, 8'h12, 8'h00, 8'h5A};
    op(1'b0, 0);
    $display("test unlock_guard done");
    unlock(1'b1);
    tx = {CMD_PAGE_ERASE, 8'h00, 8'hFF, 8'h00};
    op(1'b0, 0);
    tx = {CMD_BLOCK_ERASE, 8'h00, 8'h00, 8'h00};
    op(1'b1, 0);
    tx = {CMD_FULL_ERASE};
    op(1'b0, 0);
    $display("test top_lock done");
    top_block_lock_n = 1'b1;
    page = 8'($random(seed));
    foreach (ops[i]) begin
      unlock(i[0]);
      tx = {ops[i], 8'h00, page, 8'($random(seed))};
      if (ops[i] == CMD_MERGE_WRITE || ops[i] == CMD_PAGE_PROGRAM)
        repeat (($random(seed) & 7) + 1) tx.push_back(8'($random(seed)));
      op(i[1], 2);
    end
    $display("test write_cycles done");
    unlock(1'b0);
    tx = {CMD_WRITE_STATUS, 8'h08};
    op(1'b0, 3);
    unlock(1'b1);
    tx = {CMD_PAGE_ERASE, 8'h00, 8'hFF, 8'h00};
    op(1'b1, 0);
    tx = {CMD_PAGE_ERASE, 8'h00, 8'h7F, 8'h00};
    op(1'b0, 2);
    write_protect_n = 1'b0;
    exp_hw = 1'b1;
    repeat (6) @(negedge clk_sys);
    note_pins("hw_protect", 1'b0);
    unlock(1'b0);
    tx = {CMD_WRITE_STATUS, 8'h0C};
    op(1'b0, 3);
    write_protect_n = 1'b1;
    exp_hw = 1'b0;
    repeat (6) @(negedge clk_sys);
    unlock(1'b1);
    tx = {CMD_WRITE_STATUS, 8'h00};
    op(1'b1, 3);
    $display("test protect_size done");
    unlock(1'b0);
    reset_pin_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    exp_latch = 1'b0;
    note_pins("reset_pin", 1'b0);
    reset_pin_n = 1'b1;
    $display("test reset_pin done");
    final_report();
  end
endmodule : test_spi_paged_flash_write_path
